// *** logic/jin_top.sv ***
module jin_top #(
    parameter logic [31:0] PART_ID = 32'h1000_0001 // Arbitrary value
) (
    // System clock and reset
    input  wire logic                       mclk,
    input  wire logic                       arst_n,
    // Test access port
    input  wire logic                       tck,
    input  wire logic                       tms,
    input  wire logic                       tdi,
    output logic                            tdo,
    output logic                            tdoEn,
    // Boundary cells
    input  wire logic [jin_pkg::BSR_W-1:0]  bsCapture,
    output logic      [jin_pkg::BSR_W-1:0]  bsUpdate,
    output logic                            bsExtest,
    output logic                            coreForceOne,
    // Memory controller, system clock domain
    output logic                            nvmReq,
    output jin_pkg::jin_nvm_req_type        nvmCmd,
    input  wire logic                       nvmAck,
    input  wire logic [7:0]                 nvmRdata,
    input  wire logic                       nvmFail
);
    import jin_pkg::*;

    jin_tap_state_type tapState;
    logic [IR_W-1:0]  irShift_r;
    logic [IR_W-1:0]  ir_r;
    logic             bypass_r;
    logic [31:0]      idShift_r;
    logic [BSR_W-1:0] bsShift_r;
    logic [BSR_W-1:0] bsPinSync;
    logic [IND_W-1:0] indShift_r;
    jin_cmd_type      cmd_r;
    jin_cmd_type      pendCmd_r;
    logic             pend_r;
    logic             reqTgl_r;
    logic             doneSync;
    logic             busy;
    logic             indSel;
    logic [1:0]       selIdx;
    jin_cmd_type      shCmd;
    logic             tdoNxt;
    logic             extest;
    logic             sample;

    // System clock side
    logic              reqSync;
    logic              reqSeen_r;
    logic              doneTgl_r;
    jin_eng_state_type eng_r;
    logic [7:0]        ctrl_r;
    logic [16:0]       addr_r;
    logic [7:0]        scale_r;
    logic [7:0]        byte_r;
    logic              fail_r;
    logic [PAY_W-1:0]  result_r;
    logic [2:0]        wmode;
    logic [3:0]        rmode;

    jin_tap u_tap (
        .tck    (tck),
        .arst_n (arst_n),
        .tms    (tms),
        .state  (tapState)
    );

    jin_sync #(.W(BSR_W)) u_pinSync (
        .clk    (tck),
        .arst_n (arst_n),
        .din    (bsCapture),
        .dout   (bsPinSync)
    );

    jin_sync #(.W(1)) u_doneSync (
        .clk    (tck),
        .arst_n (arst_n),
        .din    (doneTgl_r),
        .dout   (doneSync)
    );

    jin_sync #(.W(1)) u_reqSync (
        .clk    (mclk),
        .arst_n (arst_n),
        .din    (reqTgl_r),
        .dout   (reqSync)
    );

    assign extest = (ir_r == IR_EXTEST);
    assign sample = (ir_r == IR_SAMPLE);
    assign indSel = (ir_r >= IR_CTRL) && (ir_r <= IR_SCALE);
    assign selIdx = ir_r[1:0] - SEL_BASE;
    assign busy   = reqTgl_r ^ doneSync;
    assign shCmd  = '{op: indShift_r[19:18], sel: selIdx, payload: indShift_r[17:0]};

    // Instruction register
    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            irShift_r <= IR_CAPTURE;
            ir_r      <= IR_IDCODE;
        end else begin
            unique case (tapState)
                TLR:     ir_r      <= IR_IDCODE;
                CAP_IR:  irShift_r <= IR_CAPTURE;
                SH_IR:   irShift_r <= {tdi, irShift_r[IR_W-1:1]};
                UPD_IR:  ir_r      <= irShift_r;
                default: ;
            endcase
        end
    end

    // Bypass and identifier
    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            bypass_r  <= 1'h0;
            idShift_r <= '0;
        end else if (tapState == CAP_DR) begin
            bypass_r  <= 1'h0;
            idShift_r <= PART_ID;
        end else if (tapState == SH_DR) begin
            bypass_r  <= tdi;
            idShift_r <= {tdi, idShift_r[31:1]};
        end
    end

    // Boundary chain
    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            bsShift_r <= '0;
            bsUpdate  <= '0;
        end else if (extest || sample) begin
            if (tapState == CAP_DR) begin
                bsShift_r <= bsPinSync;
            end else if (tapState == SH_DR) begin
                bsShift_r <= {tdi, bsShift_r[BSR_W-1:1]};
            end else if (tapState == UPD_DR) begin
                bsUpdate  <= bsShift_r;
            end
        end
    end

    // Pins follow latches only under external test
    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            bsExtest     <= 1'h0;
            coreForceOne <= 1'h0;
        end else begin
            bsExtest     <= extest;
            coreForceOne <= extest;
        end
    end

    // Indirect data register
    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            indShift_r <= '0;
        end else if (indSel && tapState == CAP_DR) begin
            indShift_r <= {1'h0, result_r, busy};
        end else if (indSel && tapState == SH_DR) begin
            indShift_r <= {tdi, indShift_r[IND_W-1:1]};
        end
    end

    // Command launch and deferral while busy
    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            cmd_r     <= '0;
            pendCmd_r <= '0;
            pend_r    <= 1'h0;
            reqTgl_r  <= 1'h0;
        end else if (indSel && tapState == UPD_DR && shCmd.op[1]) begin
            if (busy || pend_r) begin
                pendCmd_r <= shCmd;
                pend_r    <= 1'h1;
            end else begin
                cmd_r    <= shCmd;
                reqTgl_r <= ~reqTgl_r;
            end
        end else if (indSel && tapState == CAP_DR && pend_r && !busy) begin
            cmd_r    <= pendCmd_r;
            pend_r   <= 1'h0;
            reqTgl_r <= ~reqTgl_r;
        end else if (tapState == TLR) begin
            pend_r <= 1'h0;
        end
    end

    always_comb begin
        tdoNxt = bypass_r;
        if (tapState == SH_IR) begin
            tdoNxt = irShift_r[0];
        end else if (extest || sample) begin
            tdoNxt = bsShift_r[0];
        end else if (ir_r == IR_IDCODE) begin
            tdoNxt = idShift_r[0];
        end else if (indSel) begin
            tdoNxt = indShift_r[0];
        end else begin
            tdoNxt = bypass_r;
        end
    end

    // Output changes on the falling test clock edge
    always_ff @(negedge tck or negedge arst_n) begin
        if (!arst_n) begin
            tdo   <= 1'h0;
            tdoEn <= 1'h0;
        end else begin
            tdo   <= tdoNxt;
            tdoEn <= (tapState == SH_DR) || (tapState == SH_IR);
        end
    end

    assign wmode = ctrl_r[WMODE_HI:WMODE_LO];
    assign rmode = ctrl_r[RMODE_HI:RMODE_LO];

    // Indirect register engine; cmd_r is stable while a request is open
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reqSeen_r <= 1'h0;
            doneTgl_r <= 1'h0;
            eng_r     <= ENG_IDLE;
            ctrl_r    <= CTRL_RESET;
            addr_r    <= ADDR_RESET;
            scale_r   <= SCALE_RESET;
            byte_r    <= BYTE_RESET;
            fail_r    <= 1'h0;
            result_r  <= '0;
            nvmReq    <= 1'h0;
            nvmCmd    <= '0;
        end else begin
            nvmReq <= 1'h0;
            unique case (eng_r)
                ENG_IDLE: begin
                    if (reqSync != reqSeen_r) begin
                        reqSeen_r <= reqSync;
                        doneTgl_r <= ~doneTgl_r;
                        if (cmd_r.op == OP_WRITE) begin
                            unique case (cmd_r.sel)
                                SEL_CTRL:  ctrl_r  <= cmd_r.payload[17:10];
                                SEL_ADDR:  addr_r  <= cmd_r.payload[17:1];
                                SEL_SCALE: scale_r <= cmd_r.payload[17:10];
                                SEL_DATA: begin
                                    byte_r <= cmd_r.payload[17:10];
                                    if (wmode == WMODE_ERASE
                                        && cmd_r.payload[17:10] != ERASE_KEY) begin
                                        fail_r <= 1'h1;
                                    end else if (wmode != WMODE_NONE) begin
                                        doneTgl_r <= doneTgl_r;
                                        eng_r     <= ENG_MEM;
                                        nvmReq    <= 1'h1;
                                        nvmCmd    <= '{write: 1'h1,
                                                       scratch: ctrl_r[CTRL_SCRATCH],
                                                       wmode: wmode, rmode: rmode,
                                                       addr: addr_r,
                                                       wdata: cmd_r.payload[17:10],
                                                       scale: scale_r};
                                    end
                                end
                            endcase
                        end else begin
                            unique case (cmd_r.sel)
                                SEL_CTRL:  result_r <= {10'h000, ctrl_r};
                                SEL_ADDR:  result_r <= {1'h0, addr_r};
                                SEL_SCALE: result_r <= {10'h000, scale_r};
                                SEL_DATA: begin
                                    if (rmode == RMODE_NONE) begin
                                        result_r <= {9'h000, byte_r, fail_r};
                                    end else begin
                                        doneTgl_r <= doneTgl_r;
                                        eng_r     <= ENG_MEM;
                                        nvmReq    <= 1'h1;
                                        nvmCmd    <= '{write: 1'h0,
                                                       scratch: ctrl_r[CTRL_SCRATCH],
                                                       wmode: wmode, rmode: rmode,
                                                       addr: addr_r, wdata: byte_r,
                                                       scale: scale_r};
                                    end
                                end
                            endcase
                        end
                    end
                end
                ENG_MEM: begin
                    if (nvmAck) begin
                        eng_r     <= ENG_IDLE;
                        doneTgl_r <= ~doneTgl_r;
                        fail_r    <= nvmFail;
                        if (!nvmCmd.write) begin
                            byte_r   <= nvmRdata;
                            result_r <= {9'h000, nvmRdata, nvmFail};
                        end else if (nvmCmd.wmode == WMODE_WRITE && !nvmFail) begin
                            addr_r <= addr_r + 17'h00001;
                        end
                    end
                end
            endcase
        end
    end
endmodule

// *** logic/jin_pkg.sv ***
package jin_pkg;
    localparam int unsigned IR_W     = 16;
    localparam int unsigned BSR_W    = 134;
    localparam int unsigned IND_W    = 20;
    localparam int unsigned PAY_W    = 18;
    localparam int unsigned NADDR_W  = 17;
    localparam logic [15:0] IR_EXTEST  = 16'h0000;
    localparam logic [15:0] IR_SAMPLE  = 16'h0002;
    localparam logic [15:0] IR_IDCODE  = 16'h0004;
    localparam logic [15:0] IR_BYPASS  = 16'hFFFF;
    localparam logic [15:0] IR_CTRL    = 16'h0082;
    localparam logic [15:0] IR_SCALE   = 16'h0085;
    localparam logic [15:0] IR_CAPTURE = 16'h0001;
    localparam logic [1:0]  OP_READ    = 2'h2;
    localparam logic [1:0]  OP_WRITE   = 2'h3;
    localparam logic [1:0]  SEL_CTRL   = 2'h0;
    localparam logic [1:0]  SEL_DATA   = 2'h1;
    localparam logic [1:0]  SEL_ADDR   = 2'h2;
    localparam logic [1:0]  SEL_SCALE  = 2'h3;
    localparam logic [1:0]  SEL_BASE   = 2'h2;
    localparam int unsigned CTRL_SCRATCH = 7;
    localparam int unsigned WMODE_HI   = 6;
    localparam int unsigned WMODE_LO   = 4;
    localparam int unsigned RMODE_HI   = 3;
    localparam int unsigned RMODE_LO   = 0;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [7:0]  SCALE_RESET = 8'h00;
    localparam logic [16:0] ADDR_RESET  = 17'h00000;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [2:0]  WMODE_NONE  = 3'h0;
    localparam logic [2:0]  WMODE_WRITE = 3'h1;
    localparam logic [2:0]  WMODE_ERASE = 3'h2;
    localparam logic [3:0]  RMODE_NONE  = 4'h0;
    localparam logic [7:0]  ERASE_KEY   = 8'hA5;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } jin_tap_state_type;

    typedef enum logic {ENG_IDLE, ENG_MEM} jin_eng_state_type;

    typedef struct packed {
        logic [1:0]  op;
        logic [1:0]  sel;
        logic [17:0] payload;
    } jin_cmd_type;

    typedef struct packed {
        logic        write;
        logic        scratch;
        logic [2:0]  wmode;
        logic [3:0]  rmode;
        logic [16:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  scale;
    } jin_nvm_req_type;
endpackage

// *** logic/jin_sync.sv ***
module jin_sync #(
    parameter int unsigned W = 1
) (
    // Destination clock
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Level crossing
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule

// *** logic/jin_tap.sv ***
module jin_tap (
    // Test clock
    input  wire logic                       tck,
    input  wire logic                       arst_n,
    // Mode pin
    input  wire logic                       tms,
    output jin_pkg::jin_tap_state_type      state
);
    import jin_pkg::*;

    jin_tap_state_type stateNxt;

    always_comb begin
        stateNxt = state;
        unique case (state)
            TLR:    stateNxt = tms ? TLR : RTI;
            RTI:    stateNxt = tms ? SEL_DR : RTI;
            SEL_DR: stateNxt = tms ? SEL_IR : CAP_DR;
            CAP_DR: stateNxt = tms ? EX1_DR : SH_DR;
            SH_DR:  stateNxt = tms ? EX1_DR : SH_DR;
            EX1_DR: stateNxt = tms ? UPD_DR : PA_DR;
            PA_DR:  stateNxt = tms ? EX2_DR : PA_DR;
            EX2_DR: stateNxt = tms ? UPD_DR : SH_DR;
            UPD_DR: stateNxt = tms ? SEL_DR : RTI;
            SEL_IR: stateNxt = tms ? TLR : CAP_IR;
            CAP_IR: stateNxt = tms ? EX1_IR : SH_IR;
            SH_IR:  stateNxt = tms ? EX1_IR : SH_IR;
            EX1_IR: stateNxt = tms ? UPD_IR : PA_IR;
            PA_IR:  stateNxt = tms ? EX2_IR : PA_IR;
            EX2_IR: stateNxt = tms ? UPD_IR : SH_IR;
            UPD_IR: stateNxt = tms ? SEL_DR : RTI;
        endcase
    end

    always_ff @(posedge tck or negedge arst_n) begin
        if (!arst_n) begin
            state <= TLR;
        end else begin
            state <= stateNxt;
        end
    end
endmodule

// *** bench/jin_chk.sv ***
module jin_chk (
    // Clocks and reset
    input wire logic                      mclk,
    input wire logic                      arst_n,
    input wire logic                      tck,
    // Test access port
    input wire logic                      tms,
    input wire logic                      tdi,
    input wire logic                      tdo,
    input wire logic                      tdoEn,
    // Boundary cells
    input wire logic [jin_pkg::BSR_W-1:0] bsCapture,
    input wire logic [jin_pkg::BSR_W-1:0] bsUpdate,
    input wire logic                      bsExtest,
    input wire logic                      coreForceOne,
    // Memory controller
    input wire logic                      nvmReq,
    input jin_pkg::jin_nvm_req_type       nvmCmd,
    input wire logic                      nvmAck,
    input wire logic [7:0]                nvmRdata,
    input wire logic                      nvmFail
);
    timeunit 1ns;
    timeprecision 1ps;
    import jin_pkg::*;

    logic outst_r;

    // One memory request outstanding until its acknowledge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) outst_r <= 1'b0;
        else if (nvmReq) outst_r <= 1'b1;
        else if (nvmAck) outst_r <= 1'b0;
    end

    sequence memRead;
        nvmReq && !nvmCmd.write;
    endsequence
    sequence memWrite;
        nvmReq && nvmCmd.write;
    endsequence

    AST_REQ_PULSE: assert property (@(posedge mclk) disable iff (!arst_n)
        nvmReq |=> !nvmReq) else $error("request held over one cycle");
    AST_ONE_OUT: assert property (@(posedge mclk) disable iff (!arst_n)
        nvmReq |-> !outst_r) else $error("request while busy");
    AST_CMD_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
        !nvmReq |-> $stable(nvmCmd)) else $error("command moved without request");
    AST_RD_MODE: assert property (@(posedge mclk) disable iff (!arst_n)
        memRead |-> nvmCmd.rmode != RMODE_NONE) else $error("memory read in mode 0");
    AST_WR_MODE: assert property (@(posedge mclk) disable iff (!arst_n)
        memWrite |-> nvmCmd.wmode != WMODE_NONE) else $error("memory write in mode 0");
    AST_FORCE: assert property (@(posedge tck) disable iff (!arst_n)
        coreForceOne == bsExtest) else $error("force and pad select differ");
    AST_SHIFT_IN: assert property (@(posedge tck) disable iff (!arst_n)
        $rose(tdoEn) |-> !$past(tms)) else $error("shift entered with mode high");
    AST_SHIFT_OUT: assert property (@(posedge tck) disable iff (!arst_n)
        $fell(tdoEn) |-> $past(tms)) else $error("shift left with mode low");
endmodule

bind jin_top jin_chk chk_u (.mclk(mclk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoEn(tdoEn), .bsCapture(bsCapture), .bsUpdate(bsUpdate),
    .bsExtest(bsExtest), .coreForceOne(coreForceOne), .nvmReq(nvmReq), .nvmCmd(nvmCmd),
    .nvmAck(nvmAck), .nvmRdata(nvmRdata), .nvmFail(nvmFail));

// *** bench/jin_host.sv ***
module jin_host (
    // Link pins
    output logic     tck,
    output logic     tms,
    output logic     tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ps;

    // Test clock stands low outside frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // One 6 ns test clock, output sampled at the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #3 tck = 1'b1;
        q = tdo;
        #3 tck = 1'b0;
    endtask

    // From idle: select, capture, shift n bits LSB first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [133:0] d,
                        output logic [133:0] q);
        logic x;
        q = '0;
        step(1'b1, 1'b0, x);
        if (ir) step(1'b1, 1'b0, x);
        step(1'b0, 1'b0, x);
        step(1'b0, 1'b0, x);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], x);
            q[i] = x;
        end
        step(1'b1, 1'b0, x);
        step(1'b0, 1'b0, x);
    endtask
endmodule

// *** bench/test_jtag_indirect_nvm_access.sv ***
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end

module test_jtag_indirect_nvm_access;
    timeunit 1ns;
    timeprecision 1ps;
    import jin_pkg::*;

    localparam logic [31:0]  PART = 32'h2468_ACE1; // Arbitrary value
    localparam logic [16:0]  ADDR = 17'h1ABCD;
    localparam logic [133:0] PAT  = {67{2'b10}};
    localparam logic [133:0] UPD  = {{67{1'b1}}, {67{1'b0}}};

    logic             mclk = 1'b0;
    logic             arst_n = 1'b0;
    logic [BSR_W-1:0] bsCapture = '0;
    logic             nvmAck = 1'b0;
    logic [7:0]       nvmRdata = 8'h00;
    logic             nvmFail = 1'b0;
    wire              tck, tms, tdi;
    logic             tdo, tdoEn, bsExtest, coreForceOne, nvmReq;
    logic [BSR_W-1:0] bsUpdate;
    jin_nvm_req_type  nvmCmd, lastCmd;
    logic [7:0]       memByte = 8'h00;
    logic             memFail = 1'b0;
    int               mismatches = 0, comparisons = 0, cycles = 0;
    int               ackDelay = 2, ackCnt = 0, reqCount = 0;

    always #5 mclk = ~mclk;

    jin_top #(.PART_ID(PART)) dut_u (.mclk(mclk), .arst_n(arst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn), .bsCapture(bsCapture), .bsUpdate(bsUpdate),
        .bsExtest(bsExtest), .coreForceOne(coreForceOne), .nvmReq(nvmReq), .nvmCmd(nvmCmd),
        .nvmAck(nvmAck), .nvmRdata(nvmRdata), .nvmFail(nvmFail));
    jin_host host_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    // Memory controller: acknowledge after ackDelay, data garbled outside it
    always @(posedge mclk) begin
        nvmAck <= 1'b0;
        nvmRdata <= ~memByte;
        nvmFail <= ~memFail;
        if (nvmReq) begin
            reqCount <= reqCount + 1;
            lastCmd <= nvmCmd;
            ackCnt <= ackDelay;
        end else if (ackCnt != 0) begin
            ackCnt <= ackCnt - 1;
            if (ackCnt == 1) begin
                nvmAck <= 1'b1;
                nvmRdata <= memByte;
                nvmFail <= memFail;
            end
        end
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    task automatic results();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic dr(input int n, input logic [133:0] d, output logic [133:0] q);
        host_u.scan(1'b0, n, d, q);
    endtask

    task automatic ir(input logic [15:0] c);
        logic [133:0] q;
        logic         x;
        host_u.scan(1'b1, 16, 134'(c), q);
        `CHK(q[15:0], IR_CAPTURE)
        // One idle clock lets the pad-control flops follow the new instruction
        host_u.step(1'b0, 1'b0, x);
    endtask

    // Single-bit polls until busy reads low
    task automatic idle();
        logic [133:0] q;
        int k;
        k = 0;
        do begin
            dr(1, 134'h0, q);
            k++;
        end while (q[0] !== 1'b0 && k < 300);
        `CHK(q[0], 1'b0)
    endtask

    task automatic wreg(input logic [15:0] c, input int w, input logic [17:0] v);
        logic [133:0] q;
        ir(c);
        dr(w + 2, (134'h3 << w) | 134'(v), q);
        idle();
    endtask

    task automatic rreg(input int w, output logic [17:0] v);
        logic [133:0] q;
        dr(2, 134'h2, q);
        idle();
        dr(w + 1, 134'h0, q);
        v = 18'((q >> 1) & ((134'h1 << w) - 134'h1));
    endtask

    task automatic tIdent();
        logic [133:0] q;
        dr(32, 134'h0, q);
        `CHK(q[31:0], PART)
        ir(IR_BYPASS);
        dr(8, 134'hA5, q);
        `CHK(q[7:0], 8'h4A)
        ir(IR_IDCODE);
        dr(32, 134'h0, q);
        `CHK(q[31:0], PART)
    endtask

    task automatic tRegs();
        logic [133:0] q;
        logic [17:0] v;
        ir(IR_CTRL);
        rreg(8, v);
        `CHK(v[7:0], CTRL_RESET)
        wreg(IR_CTRL, 8, 18'h11);
        rreg(8, v);
        `CHK(v[7:0], 8'h11)
        wreg(IR_SCALE, 8, 18'hC4);
        rreg(8, v);
        `CHK(v[7:0], 8'hC4)
        wreg(16'h0084, 17, 18'(ADDR));
        dr(2, 134'h2, q);
        idle();
        dr(20, 134'h0, q);
        `CHK(q[19:0], {2'b00, ADDR, 1'b0})
    endtask

    task automatic tMem();
        logic [17:0] v;
        int c0;
        ir(16'h0083);
        memByte = 8'hC3;
        rreg(9, v);
        `CHK(v[8:0], {8'hC3, 1'b0})
        `CHK({lastCmd.write, lastCmd.addr, lastCmd.rmode}, {1'b0, ADDR, 4'h1})
        memFail = 1'b1;
        rreg(9, v);
        `CHK(v[0], 1'b1)
        memFail = 1'b0;
        wreg(16'h0083, 8, 18'hA7);
        `CHK({lastCmd.write, lastCmd.wdata, lastCmd.addr}, {1'b1, 8'hA7, ADDR})
        ir(16'h0084);
        rreg(17, v);
        `CHK(v[16:0], ADDR + 17'h1)
        // Erase mode with a wrong key fails locally; stored byte is read back
        wreg(IR_CTRL, 8, 18'h20);
        wreg(16'h0083, 8, 18'h5A);
        rreg(9, v);
        `CHK(v[8:0], {8'h5A, 1'b1})
        c0 = reqCount;
        wreg(16'h0083, 8, 18'(ERASE_KEY));
        `CHK(reqCount, c0 + 1)
        `CHK(lastCmd.wmode, WMODE_ERASE)
        wreg(IR_CTRL, 8, 18'h11);
    endtask

    task automatic tBusy();
        logic [133:0] q;
        int c0;
        ackDelay = 60;
        c0 = reqCount;
        ir(16'h0083);
        dr(2, 134'h2, q);
        dr(2, 134'h2, q);
        repeat (5) @(posedge mclk);
        `CHK(q[0], 1'b1)
        `CHK(reqCount, c0 + 1)
        idle();
        repeat (10) @(posedge mclk);
        `CHK(reqCount, c0 + 2)
        ackDelay = 2;
        idle();
    endtask

    task automatic tBound();
        logic [133:0] q;
        @(posedge mclk) bsCapture <= PAT;
        ir(IR_SAMPLE);
        `CHK({bsExtest, coreForceOne}, 2'b00)
        dr(134, UPD, q);
        `CHK(q, PAT)
        `CHK(bsUpdate, UPD)
        ir(IR_EXTEST);
        `CHK({bsExtest, coreForceOne}, 2'b11)
        dr(134, ~UPD, q);
        `CHK(q, PAT)
        `CHK(bsUpdate, ~UPD)
        ir(IR_BYPASS);
        `CHK(bsExtest, 1'b0)
    endtask

    initial begin
        logic x;
        repeat (3) host_u.step(1'b1, 1'b0, x);
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        host_u.step(1'b0, 1'b0, x);
        tIdent();
        tRegs();
        tMem();
        tBusy();
        tBound();
        results();
    end
endmodule
